// ### logic/loader_map.svh
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH

// serial header and frame codes, read left to right
`define PRE_SER       4'h2
`define CHECK_SER     4'h6
`define POST_SER      8'h7F
`define LEN_LAST      16'h0017
`define FILL_LAST     16'h0003
`define CHECK_LAST    16'h0003
`define POST_LAST     16'h0007

// byte-wide codes, written with line zero as the leftmost bit
`define PRE_EXP       8'hF2
`define FCHK_EXP      8'hD2
`define START_EXP     8'hFE
`define HDR_BYTE_LAST 16'h0002

// user pins released this many link clocks after start-up begins
`define RELEASE_CLKS  2'h2

// master clock generation, 125 MHz system clock
`define CLK_MHZ       125
`define SLOW_HALF_NS  500
`define FAST_HALF_NS  125
`define SLOW_HALF_CYC ((`SLOW_HALF_NS * `CLK_MHZ) / 1000)
`define FAST_HALF_CYC ((`FAST_HALF_NS * `CLK_MHZ) / 1000)

`endif

// ### logic/loader_pkg.sv
package loader_pkg;

	typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_EXP} mode_t;

	typedef enum logic [4:0] {
		ST_IDLE, S_HUNT, S_LEN, S_FILL, S_START, S_DATA, S_CHECK,
		S_POST, S_PASS, E_HUNT, E_LEN, E_FILL, E_FCHK, E_START,
		E_DATA, E_CHECK, E_FULL, ST_ERR
	} ld_state_t;

endpackage

// ### logic/config_clock_if.sv
interface config_clock_if;
	logic run;
	logic fast;
	logic config_clock;
	logic rise;
	logic fall;

	modport gen (input run, input fast, output config_clock, output rise, output fall);
	modport user (output run, output fast, input config_clock, input rise, input fall);
endinterface

// ### logic/pin_sync.sv
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// two stages; the first is read only by the second
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ### logic/config_clock_gen.sv
`include "loader_map.svh"

module config_clock_gen (
	input  wire logic clk,
	input  wire logic rst_n,
	config_clock_if.gen       g
);
	logic [7:0] cnt_r;
	logic [7:0] half;

	// fast rate only once selected; always starts slow
	assign half = g.fast ? 8'(`FAST_HALF_CYC) : 8'(`SLOW_HALF_CYC);

	// divider toggles the clock every half period, edges as pulses
	always_ff @(posedge clk)
	begin
		if (!rst_n || !g.run)
		begin
			cnt_r  <= 8'h00;
			g.config_clock <= 1'b0;
			g.rise <= 1'b0;
			g.fall <= 1'b0;
		end
		else if (cnt_r == half - 8'h01)
		begin
			cnt_r  <= 8'h00;
			g.config_clock <= !g.config_clock;
			g.rise <= !g.config_clock;
			g.fall <= g.config_clock;
		end
		else
		begin
			cnt_r  <= cnt_r + 8'h01;
			g.rise <= 1'b0;
			g.fall <= 1'b0;
		end
	end

	property p_half_period;
		@(posedge clk) disable iff (!rst_n)
		(g.run && !g.fast && g.rise) |-> ##1 (g.run && !g.fall) [*8];
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("generated clock edge came too early");
endmodule

// ### logic/config_loader.sv
// Summary of operation
// - pass the header on serial out; catch length count after 0010 preamble.
// - after length count, hold serial out high until own frames are loaded.
// - once own load is done, forward further bits resynchronised on serial out.
// - count link clocks from init; start up when count equals length count.
// - in serial modes release user pins two link clocks after start-up begins.
// - byte-wide mode takes a whole byte on each link clock rise.
// - byte-wide mode checks constant fields, no length count; done ends it.
// - upper mode input low selects byte-wide mode whatever the lower input.
// - first byte by the second rise; then one byte per rise.
// - byte-wide frame data taken only with chain select high, memory not full.
// - byte-wide status out low after header, high once memory is full.
// - chain select of the first device is tied high; internal pull-up on.
// - byte-wide mode releases user pins only after its done line is high.
// - done is open drain, never driven high; pull-up on unless disabled.
// - master clock runs slow by default, fast from the first frame data bit when the option selects it.
// - header is ones, preamble, 24-bit length, then 4 fill bits.
// - serial frames open with a zero bit and close with a 4-bit check.
// - serial mode recognises the postamble ending its own data.
// - byte-wide mode uses fixed preamble, field check and start codes.
`include "loader_map.svh"

module config_loader
	import loader_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// link pins, asynchronous
	input  wire logic        config_clock_in,
	input  wire logic        serial_in,
	input  wire logic [7:0]  byte_data_lines,
	input  wire logic        chain_select_in,
	input  wire logic        mode_select_hi,
	input  wire logic        mode_select_lo,
	input  wire logic        init_line_in,
	input  wire logic        done_line_in,
	// options and memory geometry, same clock
	input  wire logic        mem_init_done,
	input  wire logic        fast_rate_opt,
	input  wire logic        crc_on,
	input  wire logic        done_pullup_off,
	input  wire logic [15:0] frame_len,
	input  wire logic [15:0] frame_total,
	// pins driven
	output logic             serial_out,
	output logic             config_clock_out,
	output logic             config_clock_oe,
	output logic             done_out,
	output logic             done_oe,
	output logic             done_pullup_en,
	output logic             init_out,
	output logic             init_oe,
	output logic             chain_select_pullup,
	// toward configuration memory
	output logic             mem_wr,
	output logic [7:0]       mem_data,
	output logic             mem_is_byte,
	output logic             io_release,
	output logic             load_error
);
	logic [7:0]  bd_s;
	logic        sclk_s, din_s, cs_s, m1_s, m0_s, init_s, done_s;
	logic        sclk_d_r, rise_ev, fall_ev, start_ev;
	logic        active_r, skip_r, fast_r, startup_r, out_bit_r;
	mode_t       mode_r;
	ld_state_t   st_r;
	logic [15:0] cnt_r, frame_r;
	logic [7:0]  sh_r;
	logic [23:0] len_r, clk_cnt_r;
	logic        len_valid_r;
	logic [1:0]  rel_r;
	logic        ser, exp_take;
	logic [3:0]  nib;
	logic [7:0]  oct, rb;

	config_clock_if g ();

	pin_sync #(.W(15)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({config_clock_in, serial_in, byte_data_lines,
		         chain_select_in, mode_select_hi, mode_select_lo,
		         init_line_in, done_line_in}),
		.q     ({sclk_s, din_s, bd_s, cs_s, m1_s, m0_s, init_s, done_s})
	);

	config_clock_gen u_gen (
		.clk   (clk),
		.rst_n (rst_n),
		.g     (g.gen)
	);

	// byte lines carry the first stream bit on line zero
	function automatic logic [7:0] rev8(input logic [7:0] v);
		rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction

	function automatic logic at_last(input logic [15:0] c, input logic [15:0] n);
		at_last = (c == n - 16'h0001);
	endfunction

	// master mode drives the link clock, other modes sample it
	assign g.run   = active_r && (mode_r == MODE_MASTER);
	assign g.fast  = fast_r;
	assign rise_ev = g.run ? g.rise : (sclk_s && !sclk_d_r);
	assign fall_ev = g.run ? g.fall : (!sclk_s && sclk_d_r);
	// loading waits for released init line, the source holds off too
	assign start_ev = !active_r && mem_init_done && init_s;
	assign ser      = (mode_r != MODE_EXP);
	assign nib      = {sh_r[2:0], din_s};
	assign oct      = {sh_r[6:0], din_s};
	assign rb       = rev8(bd_s);
	// not selected or already full: bytes on the bus belong to others
	assign exp_take = rise_ev && !skip_r && cs_s;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sclk_s;
	end

	// mode pins are caught once, when loading starts
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			active_r <= 1'b0;
			mode_r   <= MODE_SLAVE;
			skip_r   <= 1'b0;
		end
		else if (start_ev)
		begin
			active_r <= 1'b1;
			skip_r   <= 1'b1;
			if (!m1_s)
				mode_r <= MODE_EXP;
			else if (!m0_s)
				mode_r <= MODE_MASTER;
			else
				mode_r <= MODE_SLAVE;
		end
		else if (rise_ev)
			skip_r <= 1'b0;
	end

	// stream parser, one bit or one byte per link clock rise
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r        <= ST_IDLE;
			cnt_r       <= 16'h0000;
			frame_r     <= 16'h0000;
			sh_r        <= 8'h00;
			len_r       <= 24'h000000;
			len_valid_r <= 1'b0;
			mem_wr      <= 1'b0;
			mem_data    <= 8'h00;
			mem_is_byte <= 1'b0;
			load_error  <= 1'b0;
		end
		else
		begin
			mem_wr <= 1'b0;
			if (st_r == ST_IDLE && start_ev)
				st_r <= !m1_s ? E_HUNT : S_HUNT;
			else if (ser && rise_ev)
			begin
				sh_r <= oct;
				case (st_r)
				S_HUNT:
					if (nib == `PRE_SER)
					begin
						st_r  <= S_LEN;
						cnt_r <= 16'h0000;
					end
				S_LEN:
				begin
					len_r <= {len_r[22:0], din_s};
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == `LEN_LAST)
					begin
						st_r        <= S_FILL;
						len_valid_r <= 1'b1;
						cnt_r       <= 16'h0000;
					end
				end
				S_FILL:
				begin
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == `FILL_LAST)
						st_r <= S_START;
				end
				S_START:
					if (!din_s)
					begin
						st_r  <= S_DATA;
						cnt_r <= 16'h0000;
					end
				S_DATA:
				begin
					mem_wr      <= 1'b1;
					mem_data    <= {7'h00, din_s};
					mem_is_byte <= 1'b0;
					cnt_r       <= cnt_r + 16'h0001;
					if (at_last(cnt_r, frame_len))
					begin
						st_r  <= S_CHECK;
						cnt_r <= 16'h0000;
					end
				end
				S_CHECK:
				begin
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == `CHECK_LAST)
					begin
						cnt_r   <= 16'h0000;
						frame_r <= frame_r + 16'h0001;
						if (!crc_on && nib != `CHECK_SER)
						begin
							st_r       <= ST_ERR;
							load_error <= 1'b1;
						end
						else if (at_last(frame_r, frame_total))
							st_r <= S_POST;
						else
							st_r <= S_START;
					end
				end
				S_POST:
				begin
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == `POST_LAST)
					begin
						if (oct == `POST_SER)
							st_r <= S_PASS;
						else
						begin
							st_r       <= ST_ERR;
							load_error <= 1'b1;
						end
					end
				end
				default:
					st_r <= st_r;
				endcase
			end
			else if (!ser && exp_take)
			begin
				case (st_r)
				E_HUNT:
					if (rb == `PRE_EXP)
					begin
						st_r  <= E_LEN;
						cnt_r <= 16'h0000;
					end
				E_LEN, E_FILL:
				begin
					// length bytes are not used here
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == `HDR_BYTE_LAST)
					begin
						st_r  <= (st_r == E_LEN) ? E_FILL : E_FCHK;
						cnt_r <= 16'h0000;
					end
				end
				E_FCHK, E_CHECK:
					if (rb != `FCHK_EXP)
					begin
						st_r       <= ST_ERR;
						load_error <= 1'b1;
					end
					else if (st_r == E_FCHK)
						st_r <= E_START;
					else
					begin
						frame_r <= frame_r + 16'h0001;
						st_r    <= at_last(frame_r, frame_total)
						           ? E_FULL : E_START;
					end
				E_START:
					if (rb == `START_EXP)
					begin
						st_r  <= E_DATA;
						cnt_r <= 16'h0000;
					end
					else
					begin
						st_r       <= ST_ERR;
						load_error <= 1'b1;
					end
				E_DATA:
				begin
					mem_wr      <= 1'b1;
					mem_data    <= bd_s;
					mem_is_byte <= 1'b1;
					cnt_r       <= cnt_r + 16'h0001;
					if (at_last(cnt_r, frame_len))
						st_r <= E_CHECK;
				end
				default:
					st_r <= st_r;
				endcase
			end
		end
	end

	// length count against link clocks; needs trailing start-up clocks
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clk_cnt_r  <= 24'h000000;
			startup_r  <= 1'b0;
			rel_r      <= 2'h0;
			io_release <= 1'b0;
			fast_r     <= 1'b0;
		end
		else
		begin
			if (fast_rate_opt && st_r == S_DATA)
				fast_r <= 1'b1;
			if (active_r && ser && rise_ev)
			begin
				clk_cnt_r <= clk_cnt_r + 24'h000001;
				// a failed check suspends the load: no start-up, done stays low
				if (len_valid_r && !load_error
				    && clk_cnt_r + 24'h000001 == len_r)
					startup_r <= 1'b1;
				if (startup_r && rel_r != `RELEASE_CLKS)
					rel_r <= rel_r + 2'h1;
			end
			if (ser && rel_r == `RELEASE_CLKS)
				io_release <= 1'b1;
			if (!ser && st_r == E_FULL && done_s)
				io_release <= 1'b1;
		end
	end

	// serial out: header passes through, then ones, then overflow
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			out_bit_r  <= 1'b1;
			serial_out <= 1'b1;
		end
		else if (!ser)
			serial_out <= (st_r == E_FULL);
		else
		begin
			if (rise_ev)
			begin
				if (st_r == S_HUNT || st_r == S_LEN || st_r == ST_IDLE)
					out_bit_r <= din_s;
				else if (st_r == S_PASS)
					out_bit_r <= din_s;
				else
					out_bit_r <= 1'b1;
			end
			// change on the falling edge so the next device has setup
			if (fall_ev)
				serial_out <= out_bit_r;
		end
	end

	// open-drain lines only ever pull low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			done_out            <= 1'b0;
			done_oe             <= 1'b1;
			done_pullup_en      <= 1'b1;
			init_out            <= 1'b0;
			init_oe             <= 1'b1;
			chain_select_pullup <= 1'b1;
			config_clock_out    <= 1'b0;
			config_clock_oe     <= 1'b0;
		end
		else
		begin
			done_out            <= 1'b0;
			done_oe             <= !(ser ? startup_r : st_r == E_FULL);
			done_pullup_en      <= !done_pullup_off;
			init_out            <= 1'b0;
			init_oe             <= !mem_init_done || load_error;
			chain_select_pullup <= 1'b1;
			config_clock_out    <= g.config_clock;
			config_clock_oe     <= g.run;
		end
	end

	property p_len_capture;
		@(posedge clk) disable iff (!rst_n)
		(ser && rise_ev && st_r == S_HUNT && nib == `PRE_SER) |=> st_r == S_LEN;
	endproperty
	a_len_capture: assert property (p_len_capture)
		else $error("preamble seen but length capture not entered");

	property p_hold_high;
		@(posedge clk) disable iff (!rst_n)
		(ser && fall_ev && st_r inside {S_START, S_DATA, S_CHECK})
		|=> serial_out;
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("serial out low while own frames load");

	property p_forward;
		@(posedge clk) disable iff (!rst_n)
		(ser && st_r == S_PASS && $past(st_r) == S_PASS && rise_ev)
		|=> out_bit_r == $past(din_s);
	endproperty
	a_forward: assert property (p_forward)
		else $error("overflow bit not forwarded");

	property p_startup;
		@(posedge clk) disable iff (!rst_n)
		(active_r && ser && rise_ev && len_valid_r && !load_error
		 && clk_cnt_r + 24'h000001 == len_r) |=> startup_r;
	endproperty
	a_startup: assert property (p_startup)
		else $error("start-up missed at length count");

	property p_release_serial;
		@(posedge clk) disable iff (!rst_n)
		(ser && $rose(io_release)) |-> $past(rel_r) == `RELEASE_CLKS;
	endproperty
	a_release_serial: assert property (p_release_serial)
		else $error("user pins released at wrong time");

	property p_mode;
		@(posedge clk) disable iff (!rst_n)
		(start_ev && !m1_s) |=> mode_r == MODE_EXP;
	endproperty
	a_mode: assert property (p_mode)
		else $error("upper mode input low but byte mode not chosen");

	property p_take_cs;
		@(posedge clk) disable iff (!rst_n)
		(mem_wr && mem_is_byte) |-> $past(cs_s) && $past(st_r) != E_FULL;
	endproperty
	a_take_cs: assert property (p_take_cs)
		else $error("byte taken while not selected");

	property p_status;
		@(posedge clk) disable iff (!rst_n)
		(!ser && st_r inside {E_START, E_DATA, E_CHECK}) |=> !serial_out;
	endproperty
	a_status: assert property (p_status)
		else $error("status out high before memory full");

	property p_release_exp;
		@(posedge clk) disable iff (!rst_n)
		(!ser && $rose(io_release)) |-> $past(done_s) && $past(st_r) == E_FULL;
	endproperty
	a_release_exp: assert property (p_release_exp)
		else $error("byte mode released pins before done high");

	property p_open_drain;
		@(posedge clk) disable iff (!rst_n)
		!done_out && !init_out;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain line driven high");
endmodule

// ### sim/cfg_source.sv
module cfg_source (
	// system side
	input  wire logic       clk,
	input  wire logic       init_line_in,
	input  wire logic       config_clock_out,
	// link pins toward the loader
	output logic            config_clock_in,
	output logic            serial_in,
	output logic [7:0]      byte_data_lines
);
	timeunit 1ns;
	timeprecision 1ps;

	// link clock stands low between units
	initial
	begin
		config_clock_in = 1'b0;
		serial_in = 1'b1;
		byte_data_lines = 8'hFF;
	end

	// no data until the wired init line is released, bounded wait
	task automatic wait_init();
		int n;
		n = 0;
		while (init_line_in !== 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
	endtask

	// one link clock: data set while low, held over the rise and high phase
	task automatic unit(input logic b, input logic [7:0] d);
		@(negedge clk);
		serial_in = b;
		byte_data_lines = d;
		repeat (3) @(negedge clk);
		config_clock_in = 1'b1;
		repeat (4) @(negedge clk);
		config_clock_in = 1'b0;
		// hold time is over: show the inverse so stale data never matches
		serial_in = ~b;
		byte_data_lines = ~d;
	endtask

	// master mode: next bit just after each rise of the loader's clock
	task automatic follow(input logic b);
		@(posedge config_clock_out);
		@(negedge clk);
		serial_in = b;
	endtask
endmodule

// ### sim/config_loader_tb.sv
module config_loader_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_n, chain_select_in, mode_select_hi, mode_select_lo;
	logic mem_init_done, fast_rate_opt, crc_on, done_pullup_off, other_low;
	logic [15:0] frame_len, frame_total;
	wire logic config_clock_in, serial_in, init_line_in, done_line_in;
	wire logic [7:0] byte_data_lines, mem_data;
	wire logic serial_out, config_clock_out, config_clock_oe, done_out;
	wire logic done_oe, done_pullup_en, init_out, init_oe;
	wire logic chain_select_pullup, mem_wr, mem_is_byte, io_release;
	wire logic load_error;
	int fails, compares, wr_cnt;
	logic [7:0] wr_bits;
	logic wr_kind;
	logic [31:0] wr_bytes;
	logic q[$];
	logic [7:0] bseq [22] = '{8'hFF, 8'hF2, 8'h00, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'hFF, 8'hD2, 8'hFE, 8'h81, 8'h3C, 8'hD2, 8'hAA, 8'hFE,
		8'h5A, 8'h24, 8'hD2, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	// wired open-drain lines, each with a pull-up
	assign init_line_in = !init_oe;
	assign done_line_in = !(done_oe || other_low);

	config_loader u_dut (.clk, .rst_n, .config_clock_in, .serial_in,
		.byte_data_lines, .chain_select_in, .mode_select_hi,
		.mode_select_lo, .init_line_in, .done_line_in, .mem_init_done,
		.fast_rate_opt, .crc_on, .done_pullup_off, .frame_len, .frame_total,
		.serial_out, .config_clock_out, .config_clock_oe, .done_out,
		.done_oe, .done_pullup_en, .init_out, .init_oe, .chain_select_pullup,
		.mem_wr, .mem_data, .mem_is_byte, .io_release, .load_error);

	cfg_source u_src (.clk, .init_line_in, .config_clock_out,
		.config_clock_in, .serial_in, .byte_data_lines);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// log of stored units, count cleared by reset
	always @(posedge clk)
	begin
		if (!rst_n)
			wr_cnt <= 0;
		else if (mem_wr === 1'b1)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_bits <= {wr_bits[6:0], mem_data[0]};
			wr_bytes <= {wr_bytes[23:0], mem_data};
			wr_kind <= mem_is_byte;
		end
	end

	task automatic chk(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic print_verdict();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic push(input logic [23:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			q.push_back(v[i]);
	endtask

	// reset held three cycles, then memory clear finishes
	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		mem_init_done = 1'b0;
		repeat (3) @(negedge clk);
		chk({serial_out, done_oe, init_oe, config_clock_oe}, 4'hE, "rst a");
		chk({chain_select_pullup, done_pullup_en, done_out}, 3'h6, "rst b");
		chk({io_release, load_error, mem_wr}, 3'h0, "rst c");
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		mem_init_done = 1'b1;
		u_src.wait_init();
	endtask

	// serial slave load of two 4-bit frames, length count 70
	task automatic serial_run(input logic bad, input logic crc);
		logic err;
		err = bad && !crc;
		mode_select_hi = 1'b1;
		mode_select_lo = 1'b1;
		crc_on = crc;
		do_reset();
		q.delete();
		push(24'h0000FF, 8);
		push(24'h000002, 4);
		push(24'h000046, 24);
		push(24'h00000F, 4);
		push(24'h00000A, 5);
		push(24'h000006, 4);
		push(24'h000005, 5);
		push(bad ? 24'h000007 : 24'h000006, 4);
		push(24'h00007F, 8);
		push(24'h000006, 4);
		push(24'h0000FF, 8);
		for (int k = 0; k < 78; k++)
		begin
			u_src.unit(q[k], 8'h00);
			if (k > 0 && (!err || k <= 58))
				chk(serial_out, (k < 37 || k > 66) ? q[k-1] : 1'b1, "sout");
			if (k == 68 && !err)
				chk({io_release, done_oe}, 2'h1, "early start");
		end
		repeat (20) @(negedge clk);
		if (err)
			chk({load_error, io_release, init_oe, done_oe, init_out},
			    5'h16, "bad check");
		else
		begin
			chk(wr_cnt, 8, "bit count");
			chk(wr_bits, 8'hA5, "bits");
			chk(wr_kind, 1'b0, "bit kind");
			chk({io_release, done_oe, load_error}, 3'h4, "start");
		end
		chk(done_out, 1'b0, "done driven");
	endtask

	// byte-wide load, one ignored byte while chain select is low
	task automatic byte_run(input logic lo);
		logic [7:0] rv;
		mode_select_hi = 1'b0;
		mode_select_lo = lo;
		other_low = 1'b1;
		do_reset();
		for (int i = 0; i < 22; i++)
		begin
			chain_select_in = (i != 13);
			rv = {<<{bseq[i]}};
			u_src.unit(1'b1, rv);
			if (i == 14)
				chk(serial_out, 1'b0, "status low");
		end
		repeat (8) @(negedge clk);
		chk(wr_cnt, 4, "byte count");
		chk(wr_bytes, 32'h813C5A24, "bytes");
		chk(wr_kind, 1'b1, "byte kind");
		chk({serial_out, done_oe, load_error}, 3'h4, "full");
		chk(io_release, 1'b0, "early io");
		other_low = 1'b0;
		repeat (10) @(negedge clk);
		chk(io_release, 1'b1, "io after done");
	endtask

	// next full high phase of the master clock, in system clock cycles
	task automatic high_len(output int n);
		n = 0;
		while (config_clock_out === 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (config_clock_out !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (config_clock_out === 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// master mode: slow half period, pull-up option, fast once data starts
	task automatic master_run();
		int n;
		mode_select_hi = 1'b1;
		mode_select_lo = 1'b0;
		do_reset();
		done_pullup_off = 1'b1;
		high_len(n);
		chk(n, 62, "slow half");
		chk({config_clock_oe, done_pullup_en}, 2'h2, "master");
		done_pullup_off = 1'b0;
		// header, fill, start bit and two data bits
		q.delete();
		push(24'h0000FF, 8);
		push(24'h000002, 4);
		push(24'h000800, 24);
		push(24'h00001E, 5);
		push(24'h000002, 2);
		for (int k = 0; k < 43; k++)
			u_src.follow(q[k]);
		high_len(n);
		chk(n, 15, "fast half");
	endtask

	initial
	begin
		rst_n = 1'b0;
		chain_select_in = 1'b1;
		mode_select_hi = 1'b1;
		mode_select_lo = 1'b1;
		mem_init_done = 1'b0;
		fast_rate_opt = 1'b1;
		crc_on = 1'b0;
		done_pullup_off = 1'b0;
		other_low = 1'b0;
		frame_len = 16'h0004;
		frame_total = 16'h0002;
		fails = 0;
		compares = 0;
		serial_run(1'b0, 1'b0);
		serial_run(1'b1, 1'b1);
		serial_run(1'b1, 1'b0);
		frame_len = 16'h0002;
		byte_run(1'b0);
		byte_run(1'b1);
		master_run();
		print_verdict();
	end

	// watchdog well beyond the expected run of a few thousand cycles
	initial
	begin
		#300000;
		fails++;
		print_verdict();
	end
endmodule
